//--- verilog/scss_consts.vh
// Constants for the system clock source select block
`ifndef SCSS_CONSTS_VH
`define SCSS_CONSTS_VH

// ==========================================================================
// Register byte offsets
`define SCSS_OFF_CTRL       8'h00
`define SCSS_OFF_STATUS     8'h04
`define SCSS_OFF_IRQ_STAT   8'h08
`define SCSS_OFF_IRQ_MASK   8'h0C

// ==========================================================================
// Control register fields
`define SCSS_CTRL_RING_SEL  0
`define SCSS_CTRL_EXT_TYPE  1
`define SCSS_CTRL_DIV_EN    2
`define SCSS_CTRL_CD_LO     3
`define SCSS_CTRL_CD_HI     4

// Status register fields
`define SCSS_STAT_RING_MODE 0
`define SCSS_STAT_WARMING   1

// Interrupt status / mask fields
`define SCSS_IRQ_SWITCHED   0
`define SCSS_IRQ_ABANDONED  1

// ==========================================================================
// Reset values
`define SCSS_RST_RING_SEL   1'b0
`define SCSS_RST_EXT_TYPE   1'b1
`define SCSS_RST_DIV_EN     1'b0
`define SCSS_RST_CD         2'h0
`define SCSS_RST_IRQ_MASK   2'h0

// ==========================================================================
// Timing counts, in source oscillator cycles
`define SCSS_RING_WARM      3'h4
`define SCSS_RC_WARM        17'h00004
`define SCSS_XT_WARM        17'h10000
`define SCSS_DIV_PM         9'h100

`endif

//--- verilog/scss_clock_select.v
// System clock source selection, warmup sequencing, divider and AHB-Lite registers
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`include "scss_consts.vh"

module scss_clock_select #(
  parameter XT_WARM = `SCSS_XT_WARM
) (
  // Clock and power-on reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Other (non power-on) reset, asynchronous source
  input  wire        soft_rst_n,
  // Oscillator and mode inputs, asynchronous
  input  wire        ring_osc_in,
  input  wire        osc_in_pin,
  input  wire        stop_mode,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Oscillator controls and generated clock
  output reg         ring_osc_en,
  output reg         ring_restart,
  output reg         xtal_amp_en,
  output reg         rc_osc_en,
  output reg         sys_clk_out,
  // Interrupt
  output reg         irq
);

  // Parked, ring warmup, ring run, external warmup and external run
  // One-hot states
  localparam [4:0] ST_STOP  = 5'h01;
  localparam [4:0] ST_RWARM = 5'h02;
  localparam [4:0] ST_RING  = 5'h04;
  localparam [4:0] ST_XWARM = 5'h08;
  localparam [4:0] ST_EXT   = 5'h10;

  // Oscillator cycles per system clock
  // Also source edges per output phase, since both source edges count
  function [8:0] scss_ratio;
    input       div_en;
    input [1:0] cd;
    begin
      if (div_en) begin
        scss_ratio = `SCSS_DIV_PM;
      end else begin
        scss_ratio = 9'h001 << cd;
      end
    end
  endfunction

  // ========================================================================
  // Reset release and input synchronisers
  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_sync_n;
  reg  [3:0] s1_q;
  reg  [3:0] s2_q;
  reg  [1:0] s3_q;

  // Power-on reset released through two flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_sync_n = rst_s2_q;

  // Two flops per asynchronous input, third flop for oscillator edges
  // Soft reset bit rests at its idle high level, so that the release of
  // power-on reset does not fake a soft reset for two cycles
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s1_q <= 4'h8;
      s2_q <= 4'h8;
      s3_q <= 2'h0;
    end else begin
      s1_q <= {soft_rst_n, stop_mode, osc_in_pin, ring_osc_in};
      s2_q <= s1_q;
      s3_q <= s2_q[1:0];
    end
  end

  // Edge strobes from the second and third flops, one cycle wide each
  wire ring_rise = s2_q[0] & ~s3_q[0];
  wire ext_rise  = s2_q[1] & ~s3_q[1];
  wire ring_edge = s2_q[0] ^ s3_q[0];
  wire ext_edge  = s2_q[1] ^ s3_q[1];
  wire stop_s    = s2_q[2];
  wire soft_rst  = ~s2_q[3];

  // ========================================================================
  // Registers and bus state
  reg        ring_sel_q;
  reg        ext_type_q;
  reg        div_en_q;
  reg  [1:0] cd_q;
  reg  [1:0] irq_stat_q;
  reg  [1:0] irq_mask_q;
  reg        pend_q;
  reg        pend_wr_q;
  reg  [7:0] pend_addr_q;
  reg  [4:0] state_q;
  reg        act_type_q;
  reg  [2:0] rcnt_q;
  reg  [16:0] xcnt_q;
  reg        ev_switch;
  reg        ev_abandon;

  // Writes land one cycle after the address phase, with the captured
  // address and the write data of the data phase
  wire wr_ctrl  = pend_q & pend_wr_q & (pend_addr_q == `SCSS_OFF_CTRL);
  wire wr_istat = pend_q & pend_wr_q & (pend_addr_q == `SCSS_OFF_IRQ_STAT);
  wire wr_imask = pend_q & pend_wr_q & (pend_addr_q == `SCSS_OFF_IRQ_MASK);
  // Last warmup count for the source type taken when the warmup began
  wire [16:0] warm_last = act_type_q ? (XT_WARM[16:0] - 17'h00001)
                                     : (`SCSS_RC_WARM - 17'h00001);

  // Ring select: only power-on reset clears it
  // Soft reset leaves it alone so that the source selection survives the park
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ring_sel_q <= `SCSS_RST_RING_SEL;
    end else if (wr_ctrl) begin
      ring_sel_q <= hwdata[`SCSS_CTRL_RING_SEL];
    end
  end

  // Source type and divider settings
  // A type write with the ring deselected is dropped; the sequencer takes
  // the type over only when the ring warmup ends or an external warmup starts
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_type_q <= `SCSS_RST_EXT_TYPE;
      div_en_q   <= `SCSS_RST_DIV_EN;
      cd_q       <= `SCSS_RST_CD;
      irq_mask_q <= `SCSS_RST_IRQ_MASK;
    end else if (soft_rst) begin
      div_en_q   <= `SCSS_RST_DIV_EN;
      cd_q       <= `SCSS_RST_CD;
      irq_mask_q <= `SCSS_RST_IRQ_MASK;
    end else begin
      if (wr_ctrl && ring_sel_q) begin
        ext_type_q <= hwdata[`SCSS_CTRL_EXT_TYPE];
      end
      if (wr_ctrl) begin
        div_en_q <= hwdata[`SCSS_CTRL_DIV_EN];
        cd_q     <= hwdata[`SCSS_CTRL_CD_HI:`SCSS_CTRL_CD_LO];
      end
      if (wr_imask) begin
        irq_mask_q <= hwdata[1:0];
      end
    end
  end

  // Sticky events: a new event wins over a write-one clear
  // Events are single-cycle pulses from the sequencer
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_istat ? hwdata[1:0] : 2'h0))
                    | {ev_abandon, ev_switch};
    end
  end

  // ========================================================================
  // Source sequencer
  // Stop and soft reset park the sequencer; every way out of the parked
  // state passes a fresh ring warmup, so the external warmup count
  // always starts from zero
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q      <= ST_RWARM;
      act_type_q   <= `SCSS_RST_EXT_TYPE;
      rcnt_q       <= 3'h0;
      xcnt_q       <= 17'h00000;
      ring_restart <= 1'b1;
      ev_switch    <= 1'b0;
      ev_abandon   <= 1'b0;
    end else begin
      ring_restart <= 1'b0;
      ev_switch    <= 1'b0;
      ev_abandon   <= 1'b0;
      if (stop_s || soft_rst) begin
        state_q <= ST_STOP;
      end else begin
        case (state_q)
          ST_STOP: begin
            state_q      <= ST_RWARM;
            rcnt_q       <= 3'h0;
            ring_restart <= 1'b1;
          end
          ST_RWARM: begin
            // Count rising ring edges; the fourth one ends the ring warmup
            if (ring_rise) begin
              rcnt_q <= rcnt_q + 3'h1;
            end
            if (ring_rise && (rcnt_q == `SCSS_RING_WARM - 3'h1)) begin
              state_q    <= ring_sel_q ? ST_RING : ST_XWARM;
              act_type_q <= ext_type_q;
              xcnt_q     <= 17'h00000;
            end
          end
          ST_RING: begin
            if (!ring_sel_q) begin
              state_q    <= ST_XWARM;
              act_type_q <= ext_type_q;
              xcnt_q     <= 17'h00000;
            end
          end
          ST_XWARM: begin
            if (ring_sel_q) begin
              state_q    <= ST_RING;
              ev_abandon <= 1'b1;
            end else if (ext_rise) begin
              xcnt_q <= xcnt_q + 17'h00001;
              if (xcnt_q == warm_last) begin
                state_q   <= ST_EXT;
                ev_switch <= 1'b1;
              end
            end
          end
          ST_EXT: begin
            if (ring_sel_q) begin
              state_q      <= ST_RING;
              ring_restart <= 1'b1;
            end
          end
          default: begin
            state_q <= ST_STOP;
          end
        endcase
      end
    end
  end

  // Oscillator enables
  // Registered, so they follow the state by one cycle; the stop input
  // gates the external cells directly as well
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ring_osc_en <= 1'b0;
      xtal_amp_en <= 1'b0;
      rc_osc_en   <= 1'b0;
    end else begin
      ring_osc_en <= (state_q != ST_EXT) && (state_q != ST_STOP);
      xtal_amp_en <= ((state_q == ST_XWARM) || (state_q == ST_EXT))
                     && act_type_q && !ring_sel_q && !stop_s;
      rc_osc_en   <= ((state_q == ST_XWARM) || (state_q == ST_EXT))
                     && !act_type_q && !ring_sel_q && !stop_s;
    end
  end

  // ========================================================================
  // System clock divider: toggles every N source edges, so one output
  // period spans N source cycles; the ratio loads only as the output
  // goes low or while it idles low, which avoids short phases
  reg        use_ext_q;
  reg  [8:0] nhalf_q;
  reg  [8:0] hc_q;
  // The divider runs in every state that has a warmed-up clock source
  wire       run = (state_q == ST_RING) || (state_q == ST_XWARM) || (state_q == ST_EXT);
  wire       want_ext = (state_q == ST_EXT);
  wire       src_edge = use_ext_q ? ext_edge : ring_edge;

  // A source that has just been gated off gives no more edges, so the
  // divider moves to the wanted source at once and restarts its count;
  // this can only stretch the current phase, never shorten it
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sys_clk_out <= 1'b0;
      use_ext_q   <= 1'b0;
      nhalf_q     <= 9'h001;
      hc_q        <= 9'h000;
    end else if (use_ext_q != want_ext) begin
      use_ext_q <= want_ext;
      hc_q      <= 9'h000;
    end else if (!run && !sys_clk_out) begin
      hc_q      <= 9'h000;
      use_ext_q <= 1'b0;
      nhalf_q   <= scss_ratio(div_en_q, cd_q);
    end else if (src_edge) begin
      if (hc_q == nhalf_q - 9'h001) begin
        hc_q        <= 9'h000;
        sys_clk_out <= ~sys_clk_out & run;
        if (sys_clk_out) begin
          use_ext_q <= (state_q == ST_EXT);
          nhalf_q   <= scss_ratio(div_en_q, cd_q);
        end
      end else begin
        hc_q <= hc_q + 9'h001;
      end
    end
  end

  // ========================================================================
  // AHB-Lite slave: one wait state, always OKAY
  // A transfer is captured in its address phase and completed in the
  // next cycle, so every data phase carries exactly one wait state
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend_q      <= 1'b0;
      pend_wr_q   <= 1'b0;
      pend_addr_q <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (pend_q) begin
        pend_q    <= 1'b0;
        hreadyout <= 1'b1;
        case (pend_addr_q)
          `SCSS_OFF_CTRL:     hrdata <= {27'h0, cd_q, div_en_q, ext_type_q, ring_sel_q};
          `SCSS_OFF_STATUS:   hrdata <= {30'h0, state_q == ST_XWARM,
                                         state_q != ST_EXT};
          `SCSS_OFF_IRQ_STAT: hrdata <= {30'h0, irq_stat_q};
          `SCSS_OFF_IRQ_MASK: hrdata <= {30'h0, irq_mask_q};
          default:            hrdata <= 32'h00000000;
        endcase
      end else if (hsel && hready && htrans[1]) begin
        pend_q      <= 1'b1;
        pend_wr_q   <= hwrite;
        pend_addr_q <= {haddr[7:2], 2'h0};
        hreadyout   <= 1'b0;
      end
    end
  end

  // Interrupt output
  // Registered, so the line follows a status or mask change by one cycle
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // scss_clock_select

//--- tb/scss_osc_model.sv
// Ring oscillator and external timing part facing the clock select block
module scss_osc_model #(
  parameter int RING_HALF = 30,
  parameter int EXT_HALF  = 50
) (
  // Enables from the block
  input  wire logic ring_osc_en,
  input  wire logic ring_restart,
  input  wire logic xtal_amp_en,
  input  wire logic rc_osc_en,
  // Oscillator outputs
  output logic      ring_osc_in,
  output logic      osc_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Ring runs only while enabled, held low through a restart pulse
  initial begin
    ring_osc_in = 1'b0;
    forever #RING_HALF ring_osc_in = ring_osc_en && !ring_restart && !ring_osc_in;
  end
  // External part stands still unless its amplifier or RC cell is on
  initial begin
    osc_in_pin = 1'b0;
    forever #EXT_HALF osc_in_pin = (xtal_amp_en || rc_osc_en) && !osc_in_pin;
  end
endmodule // scss_osc_model

//--- tb/scss_asserts.sv
// Port-level checks on the clock select block
module scss_asserts (
  // Clock and resets
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       soft_rst_n,
  // Bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Oscillator side
  input wire logic       stop_mode,
  input wire logic       ring_osc_en,
  input wire logic       ring_restart,
  input wire logic       xtal_amp_en,
  input wire logic       rc_osc_en,
  input wire logic       sys_clk_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // Bus steps and quiet mode window
  sequence s_take; hsel && hready && htrans[1] && hreadyout; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_quiet; (soft_rst_n && !stop_mode)[*4]; endsequence
  a_bus_one_wait: assert property (s_take |=> s_wait)
    else $error("bus wait state wrong");
  a_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
  a_src_exclusive: assert property (!(xtal_amp_en && rc_osc_en))
    else $error("both external cells on");
  a_stop_gates_amp: assert property (stop_mode[*5] |-> !xtal_amp_en && !rc_osc_en)
    else $error("oscillator on in stop");
  a_restart_pulse: assert property ($rose(ring_restart) |=> !ring_restart)
    else $error("ring restart not one cycle");
  a_restart_ring: assert property ($fell(ring_restart) |-> ##[0:2] ring_osc_en)
    else $error("ring not enabled after restart");
  a_warm_on_ring: assert property (($rose(xtal_amp_en) || $rose(rc_osc_en)) |-> ring_osc_en)
    else $error("warmup without ring");
  a_clk_high_hold: assert property (s_quiet ##0 $rose(sys_clk_out) |=> sys_clk_out)
    else $error("short high phase");
  a_clk_low_hold: assert property (s_quiet ##0 $fell(sys_clk_out) |=> !sys_clk_out)
    else $error("short low phase");
endmodule // scss_asserts

bind scss_clock_select scss_asserts scss_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .soft_rst_n(soft_rst_n), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .stop_mode(stop_mode), .ring_osc_en(ring_osc_en),
  .ring_restart(ring_restart), .xtal_amp_en(xtal_amp_en), .rc_osc_en(rc_osc_en),
  .sys_clk_out(sys_clk_out));

//--- tb/system_clock_source_select_test.sv
// Self-checking bench for the system clock source select block
`include "scss_consts.vh"
module system_clock_source_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals and bench state
  logic        clk_sys, rst_n, soft_rst_n, stop_mode, hsel, hwrite, prev = 0, rdph = 0;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, q;
  logic [32:0] tmp, notes[$];
  wire  [31:0] hrdata;
  wire         ring_osc_in, osc_in_pin, hreadyout, hresp, ring_osc_en, ring_restart;
  wire         xtal_amp_en, rc_osc_en, sys_clk_out, irq;
  int          miscompares = 0, checks_done = 0, seed, i, cnt = 0, last_per = 0, nrise = 0;
  scss_clock_select #(.XT_WARM(16)) scss_clock_select_inst (.clk_sys, .rst_n, .soft_rst_n,
    .ring_osc_in, .osc_in_pin, .stop_mode, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ring_osc_en,
    .ring_restart, .xtal_amp_en, .rc_osc_en, .sys_clk_out, .irq);
  scss_osc_model scss_osc_model_inst (.ring_osc_en, .ring_restart, .xtal_amp_en,
    .rc_osc_en, .ring_osc_in, .osc_in_pin);
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========
  // Compare, verdict and bus tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("miscompares %0d checks_done %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_rdy;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) return;
    end
    miscompares++;
    finish_test;
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back({1'b1, e});
    bus(a, 1'b0, 32'h0);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    for (int n = 0; n < 300; n++) begin
      notes.push_back({1'b0, 32'h0});
      bus(a, 1'b0, 32'h0);
      if ((q & m) === v) return;
    end
    miscompares++;
    finish_test;
  endtask
  task per(input int e);
    int n0;
    n0 = nrise;
    for (int n = 0; n < 20000; n++) begin
      @(posedge clk_sys);
      if (nrise == n0 + 3) begin
        chk(last_per, e, "period");
        return;
      end
    end
    miscompares++;
    finish_test;
  endtask
  // ==========
  // Read data watcher takes the oldest note at each read completion
  always @(posedge clk_sys) begin
    if (rdph && hreadyout) begin
      tmp = notes.pop_front();
      if (tmp[32]) chk(hrdata, tmp[31:0], "hrdata");
    end
    if (hreadyout) rdph <= hsel && htrans[1] && !hwrite;
  end
  // System clock period in bus clock cycles
  always @(posedge clk_sys) begin
    prev <= sys_clk_out;
    cnt <= cnt + 1;
    if (sys_clk_out && !prev) begin
      last_per <= cnt;
      cnt <= 1;
      nrise <= nrise + 1;
    end
  end
  // ==========
  // Main sequence
  initial begin
    seed = 43170;
    {rst_n, soft_rst_n, stop_mode, hsel, hwrite, haddr, htrans, hwdata} = 'h0;
    soft_rst_n = 1'b1;
    hsize = 3'h2;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(`SCSS_OFF_CTRL, 32'h2);
    poll(`SCSS_OFF_STATUS, 32'h1, 32'h0);
    rd(`SCSS_OFF_IRQ_STAT, 32'h1);
    wr(`SCSS_OFF_IRQ_MASK, 32'h3);
    @(posedge clk_sys);
    chk(irq, 32'h1, "irq");
    wr(`SCSS_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 32'h0, "irq");
    for (i = 0; i < 5; i++) begin
      wr(`SCSS_OFF_CTRL, i < 4 ? (i << 3) | 2 : 32'h6);
      per(i < 4 ? 10 << i : 2560);
    end
    wr(`SCSS_OFF_CTRL, 32'h0);
    rd(`SCSS_OFF_CTRL, 32'h2);
    wr(`SCSS_OFF_CTRL, 32'h9);
    poll(`SCSS_OFF_STATUS, 32'h1, 32'h1);
    per(12);
    rd(`SCSS_OFF_CTRL, 32'hB);
    soft_rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    soft_rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(`SCSS_OFF_CTRL, 32'h3);
    wr(`SCSS_OFF_IRQ_MASK, 32'h3);
    wr(`SCSS_OFF_IRQ_STAT, 32'h3);
    wr(`SCSS_OFF_CTRL, 32'h2);
    poll(`SCSS_OFF_STATUS, 32'h2, 32'h2);
    wr(`SCSS_OFF_CTRL, 32'h3);
    repeat (4) @(posedge clk_sys);
    rd(`SCSS_OFF_IRQ_STAT, 32'h2);
    chk(xtal_amp_en, 32'h0, "xtal_amp_en");
    chk(irq, 32'h1, "irq");
    wr(`SCSS_OFF_CTRL, 32'h1);
    rd(`SCSS_OFF_CTRL, 32'h1);
    wr(`SCSS_OFF_CTRL, 32'h0);
    poll(`SCSS_OFF_STATUS, 32'h1, 32'h0);
    chk(rc_osc_en, 32'h1, "rc_osc_en");
    wr(`SCSS_OFF_IRQ_STAT, 32'h3);
    stop_mode <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(rc_osc_en, 32'h0, "rc_osc_en");
    stop_mode <= 1'b0;
    poll(`SCSS_OFF_STATUS, 32'h3, 32'h0);
    rd(`SCSS_OFF_IRQ_STAT, 32'h1);
    wr(8'h10, $random(seed));
    rd(8'h10, 32'h0);
    finish_test;
  end
endmodule // system_clock_source_select_test
